// [brp_block_ram.sv]
// configurable dual-port block memory with shift, rom, fifo and packed use
`timescale 1ns/100ps
`default_nettype none
`include "brp_params.svh"
module brp_block_ram import brp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // configuration
  input wire brp_mode_t mode,
  input wire brp_width_t a_width,
  input wire brp_width_t b_width,
  input wire logic parity,
  input wire logic a_new_data,
  input wire logic b_new_data,
  input wire logic mixed_old,
  input wire logic [12:0] shift_len,
  // preload
  input wire logic init_en,
  input wire logic [7:0] init_row,
  input wire logic [35:0] init_data,
  // port a
  input wire logic [12:0] a_addr,
  input wire logic [35:0] a_wdata,
  input wire logic a_wren,
  input wire logic a_rden,
  input wire logic [3:0] a_byte_en,
  input wire logic a_ce_in,
  input wire logic a_ce_out,
  output logic [35:0] a_rdata,
  // port b
  input wire logic [12:0] b_addr,
  input wire logic [35:0] b_wdata,
  input wire logic b_wren,
  input wire logic b_rden,
  input wire logic [3:0] b_byte_en,
  input wire logic b_ce_in,
  input wire logic b_ce_out,
  output logic [35:0] b_rdata,
  // fifo status
  output logic fifo_full,
  output logic fifo_empty,
  output logic [13:0] fifo_count
);
  logic [35:0] mem [0:`BRP_ROWS-1];
  brp_port_if a_if();
  brp_port_if b_if();
  logic [12:0] a_addr_eff, b_addr_eff;
  logic a_wr_eff, a_rd_eff, b_wr_eff, b_rd_eff;
  logic [12:0] shift_ptr_reg, shift_ptr_next, wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [13:0] count_reg, count_next;
  logic [12:0] ptr_mask;
  logic push, pop;
  logic [7:0] a_wrow, a_rrow, b_wrow, b_rrow;
  logic [35:0] a_merged, b_base, b_merged;
  logic a_new;

  // mode steering of addresses and enables
  always_comb begin
    a_addr_eff = a_addr;
    b_addr_eff = b_addr;
    a_wr_eff = a_wren;
    a_rd_eff = a_rden;
    b_wr_eff = b_wren;
    b_rd_eff = b_rden;
    unique case (mode)
      BRP_SINGLE: begin
        b_wr_eff = 1'b0;
        b_rd_eff = 1'b0;
      end
      BRP_SIMPLE: begin
        a_rd_eff = 1'b0;
        b_wr_eff = 1'b0;
      end
      BRP_TRUE, BRP_PACKED: ;
      BRP_SHIFT: begin
        a_addr_eff = shift_ptr_reg;
        a_rd_eff = a_wren;
        b_wr_eff = 1'b0;
        b_rd_eff = 1'b0;
      end
      BRP_ROM: begin
        a_wr_eff = 1'b0;
        b_wr_eff = 1'b0;
      end
      BRP_FIFO: begin
        a_addr_eff = wr_ptr_reg;
        a_wr_eff = a_wren & ~fifo_full;
        a_rd_eff = 1'b0;
        b_addr_eff = rd_ptr_reg;
        b_wr_eff = 1'b0;
        b_rd_eff = b_rden & ~fifo_empty;
      end
    endcase
    if (init_en) begin
      a_wr_eff = 1'b0;
      a_rd_eff = 1'b0;
      b_wr_eff = 1'b0;
      b_rd_eff = 1'b0;
    end
  end

  brp_port u_port_a (
    .ref_clk(ref_clk), .arst_n(arst_n), .width(a_width), .parity(parity),
    .addr(a_addr_eff), .wdata(a_wdata), .wren(a_wr_eff), .rden(a_rd_eff),
    .byte_en(a_byte_en), .ce_in(a_ce_in), .ce_out(a_ce_out), .rdata(a_rdata), .mem(a_if)
  );
  brp_port u_port_b (
    .ref_clk(ref_clk), .arst_n(arst_n), .width(b_width), .parity(parity),
    .addr(b_addr_eff), .wdata(b_wdata), .wren(b_wr_eff), .rden(b_rd_eff),
    .byte_en(b_byte_en), .ce_in(b_ce_in), .ce_out(b_ce_out), .rdata(b_rdata), .mem(b_if)
  );

  // fifo and shift pointers count in port a words
  assign ptr_mask = `BRP_WORD_MASK >> int'(a_width);
  assign push = (mode == BRP_FIFO) & a_wr_eff & a_ce_in;
  assign pop = (mode == BRP_FIFO) & b_rd_eff & b_ce_in;
  assign fifo_full = count_reg == (`BRP_FIFO_CAP >> int'(a_width));
  assign fifo_empty = count_reg == '0;
  assign fifo_count = count_reg;

  always_comb begin
    shift_ptr_next = shift_ptr_reg;
    wr_ptr_next = push ? (wr_ptr_reg + 13'h1) & ptr_mask : wr_ptr_reg;
    rd_ptr_next = pop ? (rd_ptr_reg + 13'h1) & ptr_mask : rd_ptr_reg;
    count_next = count_reg + 14'(push) - 14'(pop);
    if (mode == BRP_SHIFT && a_wren && a_ce_in && !init_en) begin
      shift_ptr_next = (shift_ptr_reg >= shift_len - 13'h1) ? '0 : shift_ptr_reg + 13'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      shift_ptr_reg <= shift_ptr_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // packed mode pins each port to its own half of the rows
  always_comb begin
    a_wrow = a_if.wrow;
    a_rrow = a_if.rrow;
    b_wrow = b_if.wrow;
    b_rrow = b_if.rrow;
    if (mode == BRP_PACKED) begin
      a_wrow = {1'b0, a_if.wrow[6:0]};
      a_rrow = {1'b0, a_if.rrow[6:0]};
      b_wrow = {1'b1, b_if.wrow[6:0]};
      b_rrow = {1'b1, b_if.rrow[6:0]};
    end
  end

  // shift mode must see old data to form the delay line
  assign a_new = a_new_data & (mode != BRP_SHIFT);
  assign a_merged = (mem[a_wrow] & ~a_if.wmask) | (a_if.wbits & a_if.wmask);
  // same-row writes merge bit by bit under each port's mask; overlapping bits take port b
  assign b_base = (a_if.we && a_wrow == b_wrow) ? a_merged : mem[b_wrow];
  assign b_merged = (b_base & ~b_if.wmask) | (b_if.wbits & b_if.wmask);

  always_comb begin
    a_if.rd_row = mem[a_rrow];
    if (a_if.we && a_new && a_wrow == a_rrow) a_if.rd_row = a_merged;
    if (b_if.we && !mixed_old && b_wrow == a_rrow) a_if.rd_row = b_merged;
    b_if.rd_row = mem[b_rrow];
    if (b_if.we && b_new_data && b_wrow == b_rrow) b_if.rd_row = b_merged;
    if (a_if.we && !mixed_old && a_wrow == b_rrow) b_if.rd_row = a_merged;
  end

  // array contents hold through reset
  always_ff @(posedge ref_clk) begin
    if (init_en) begin
      mem[init_row] <= init_data;
    end else begin
      if (a_if.we) mem[a_wrow] <= a_merged;
      if (b_if.we) mem[b_wrow] <= b_merged;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_rom_no_write: assert property (mode == BRP_ROM && $stable(mode) |=> !a_if.we && !b_if.we)
    else $error("write reached array in rom mode");
  chk_fifo_no_overflow: assert property (mode == BRP_FIFO |->
      count_reg <= (`BRP_FIFO_CAP >> int'(a_width)))
    else $error("fifo count beyond capacity");
  chk_fifo_count_step: assert property (push && !pop |=> count_reg == $past(count_reg) + 14'h1)
    else $error("fifo count did not step on push");
  chk_byte_masked_store: assert property (a_if.we && !b_if.we && !init_en |=>
      (mem[$past(a_wrow)] & $past(a_if.wmask)) == ($past(a_if.wbits) & $past(a_if.wmask)))
    else $error("masked write not stored");
  chk_untouched_bits: assert property (a_if.we && !b_if.we && !init_en |=>
      (mem[$past(a_wrow)] & ~$past(a_if.wmask)) == ($past(mem[a_wrow]) & ~$past(a_if.wmask)))
    else $error("unmasked bits changed");
  chk_packed_halves: assert property (mode == BRP_PACKED |-> !a_wrow[7] && !a_rrow[7] && b_wrow[7])
    else $error("packed port left its half");
  chk_simple_dir: assert property (mode == BRP_SIMPLE && $stable(mode) |=> !b_if.we && !a_if.re)
    else $error("simple dual port direction broken");
  chk_same_new: assert property (a_if.we && a_new && a_wrow == a_rrow && !b_if.we |->
      (a_if.rd_row & a_if.wmask) == (a_if.wbits & a_if.wmask))
    else $error("same-port new data not forwarded");
  chk_mixed_old: assert property (mixed_old && b_if.we && !a_if.we |-> a_if.rd_row == mem[a_rrow])
    else $error("mixed-port read did not give old data");
  chk_mixed_old_b: assert property (mixed_old && a_if.we && !b_if.we |->
      b_if.rd_row == mem[b_rrow])
    else $error("port b mixed read did not give old data");
  chk_init_blocks: assert property (init_en ##1 init_en |-> !a_if.we && !b_if.we)
    else $error("user write during preload");

  cov_fifo_full: cover property (mode == BRP_FIFO && fifo_full);
  cov_mixed_rdw: cover property (a_if.re && b_if.we && a_rrow == b_wrow);
  cov_dual_write: cover property (mode == BRP_TRUE && a_if.we && b_if.we);
endmodule // brp_block_ram
`default_nettype wire

// [brp_params.svh]
// constants for the configurable block memory
`ifndef BRP_PARAMS_SVH
`define BRP_PARAMS_SVH
`define BRP_ADDR_BITS 13
`define BRP_ROWS 256
`define BRP_ROW_BITS 36
`define BRP_LANES 4
`define BRP_LANE_BITS 9
`define BRP_WORD_MASK 13'h1fff
`define BRP_FIFO_CAP 14'h2000
`define BRP_OUT_RESET 36'h0
`endif

// [brp_pkg.sv]
// types shared by the block memory modules
package brp_pkg;
  typedef enum logic [2:0] {
    BRP_SINGLE, BRP_SIMPLE, BRP_TRUE, BRP_PACKED, BRP_SHIFT, BRP_ROM, BRP_FIFO
  } brp_mode_t;
  typedef enum logic [2:0] {BRP_X1, BRP_X2, BRP_X4, BRP_X8, BRP_X16, BRP_X32} brp_width_t;
  typedef struct packed {
    logic valid;
    logic [5:0] ub;
    logic [1:0] bsel;
  } brp_bitmap_t;
endpackage

// [brp_port_if.sv]
// one port's registered access to the shared array
`timescale 1ns/100ps
`default_nettype none
interface brp_port_if;
  logic [7:0] wrow;
  logic [7:0] rrow;
  logic [35:0] wmask;
  logic [35:0] wbits;
  logic we;
  logic re;
  logic [35:0] rd_row;
  modport port (output wrow, rrow, wmask, wbits, we, re, input rd_row);
  modport array (input wrow, rrow, wmask, wbits, we, re, output rd_row);
endinterface
`default_nettype wire

// [brp_port.sv]
// one memory port: input registers, lane mapping and output register
`timescale 1ns/100ps
`default_nettype none
`include "brp_params.svh"
module brp_port import brp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // shape
  input wire brp_width_t width,
  input wire logic parity,
  // user side
  input wire logic [12:0] addr,
  input wire logic [35:0] wdata,
  input wire logic wren,
  input wire logic rden,
  input wire logic [3:0] byte_en,
  input wire logic ce_in,
  input wire logic ce_out,
  output logic [35:0] rdata,
  // array side
  brp_port_if.port mem
);
  logic [12:0] wr_addr_reg, wr_addr_next, rd_addr_reg, rd_addr_next;
  logic [35:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] be_reg, be_next;
  logic wren_reg, wren_next, rden_reg, rden_next;

  // user bit that a row bit carries, for the current width
  function automatic brp_bitmap_t map_bit(input logic [12:0] a, input int idx);
    logic [12:0] off;
    int w, base, pos, l, b, ul;
    begin
      map_bit = '0;
      w = int'(width);
      off = a << w;
      base = int'(off[4:3]);
      pos = int'(off[2:0]);
      l = idx / `BRP_LANE_BITS;
      b = idx % `BRP_LANE_BITS;
      ul = l - base;
      if (w >= 3) begin
        if (ul >= 0 && ul < (1 << (w - 3)) && (parity || b < 8)) begin
          map_bit.valid = 1'b1;
          map_bit.ub = 6'(parity ? ul * 9 + b : ul * 8 + b);
          map_bit.bsel = 2'(ul);
        end
      end else if (l == base && b >= pos && b < pos + (1 << w)) begin
        map_bit.valid = 1'b1;
        map_bit.ub = 6'(b - pos);
      end
    end
  endfunction

  // write address and data are never cleared
  always_comb begin
    wr_addr_next = wr_addr_reg;
    wdata_next = wdata_reg;
    be_next = be_reg;
    if (ce_in) begin
      wr_addr_next = addr;
      wdata_next = wdata;
      be_next = byte_en;
    end
  end

  always_ff @(posedge ref_clk) begin
    wr_addr_reg <= wr_addr_next;
    wdata_reg <= wdata_next;
    be_reg <= be_next;
  end

  // a captured request acts once, on the following edge
  always_comb begin
    brp_bitmap_t m;
    m = '0;
    rd_addr_next = ce_in ? addr : rd_addr_reg;
    wren_next = ce_in & wren;
    rden_next = ce_in & rden;
    rdata_next = rdata_reg;
    if (ce_out && rden_reg) begin
      rdata_next = '0;
      for (int i = 0; i < `BRP_ROW_BITS; i++) begin
        m = map_bit(rd_addr_reg, i);
        if (m.valid) rdata_next[m.ub] = mem.rd_row[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr_reg <= '0;
      wren_reg <= 1'b0;
      rden_reg <= 1'b0;
      rdata_reg <= `BRP_OUT_RESET;
    end else begin
      rd_addr_reg <= rd_addr_next;
      wren_reg <= wren_next;
      rden_reg <= rden_next;
      rdata_reg <= rdata_next;
    end
  end

  always_comb begin
    brp_bitmap_t m;
    m = '0;
    mem.wbits = '0;
    mem.wmask = '0;
    for (int i = 0; i < `BRP_ROW_BITS; i++) begin
      m = map_bit(wr_addr_reg, i);
      mem.wbits[i] = wdata_reg[m.ub];
      mem.wmask[i] = m.valid & be_reg[m.bsel];
    end
  end

  assign mem.wrow = 8'((wr_addr_reg << int'(width)) >> 5);
  assign mem.rrow = 8'((rd_addr_reg << int'(width)) >> 5);
  assign mem.we = wren_reg;
  assign mem.re = rden_reg;
  assign rdata = rdata_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_out_hold: assert property (!ce_out |=> $stable(rdata))
    else $error("output changed without output clock enable");
  chk_req_once: assert property (!ce_in |=> !mem.we && !mem.re)
    else $error("request acted without input clock enable");
endmodule // brp_port
`default_nettype wire

// [brp_user.sv]
// user-side model that drives both ports of the block memory
`timescale 1ns/100ps
`default_nettype none
module brp_user (
  // clock
  input wire logic ref_clk,
  // port a
  output var logic [12:0] a_addr,
  output var logic [35:0] a_wdata,
  output var logic a_wren,
  output var logic a_rden,
  output var logic [3:0] a_byte_en,
  output var logic a_ce_in,
  output var logic a_ce_out,
  // port b
  output var logic [12:0] b_addr,
  output var logic [35:0] b_wdata,
  output var logic b_wren,
  output var logic b_rden,
  output var logic [3:0] b_byte_en,
  output var logic b_ce_in,
  output var logic b_ce_out
);
  // staged request: addr, wdata, wren, rden, byte_en, ce_in, ce_out
  logic [56:0] st [2];
  task automatic drive();
    {a_addr, a_wdata, a_wren, a_rden, a_byte_en, a_ce_in, a_ce_out} = st[0];
    {b_addr, b_wdata, b_wren, b_rden, b_byte_en, b_ce_in, b_ce_out} = st[1];
  endtask
  task automatic put(int p, int ad, logic [35:0] d, logic w, logic r, logic [3:0] be);
    st[p][56:2] = {13'(ad), d, w, r, be};
  endtask
  task automatic ce(int p, logic i, logic o);
    st[p][1:0] = {i, o};
  endtask
  // requests move only just after an edge and stand one whole cycle
  task automatic go();
    @(posedge ref_clk);
    #2;
    drive();
    // idle data is inverted so a stale word never passes for a new one
    for (int p = 0; p < 2; p++) st[p][43:6] = {~st[p][43:8], 2'b00};
  endtask
  initial begin
    st[0] = 57'h3;
    st[1] = 57'h3;
    drive();
  end
endmodule // brp_user
`default_nettype wire

// [tb_brp_block_ram.sv]
// self-checking bench for the configurable block memory
`timescale 1ns/100ps
`default_nettype none
module tb_brp_block_ram import brp_pkg::*; ;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  brp_mode_t mode = BRP_ROM;
  brp_width_t a_width = BRP_X32;
  brp_width_t b_width = BRP_X32;
  logic a_new_data = 1'b0;
  logic mixed_old = 1'b1;
  logic init_en = 1'b0;
  logic [7:0] init_row = 8'h00;
  logic [35:0] init_data = 36'h0;
  logic parity = 1'b0;
  logic [12:0] shift_len = 13'h0001;
  logic [12:0] a_addr, b_addr;
  logic [35:0] a_wdata, b_wdata, a_rdata, b_rdata;
  logic a_wren, b_wren, a_rden, b_rden, a_ce_in, b_ce_in, a_ce_out, b_ce_out;
  logic [3:0] a_byte_en, b_byte_en;
  logic fifo_full, fifo_empty;
  logic [13:0] fifo_count;
  logic [31:0] seed = 32'h16c61c95;
  int fails = 0;
  int cmp_count = 0;
  bit mdl [9216];
  logic [35:0] fq [$];
  always #10 ref_clk = ~ref_clk;
  brp_user i_usr (.ref_clk, .a_addr, .a_wdata, .a_wren, .a_rden, .a_byte_en, .a_ce_in,
    .a_ce_out, .b_addr, .b_wdata, .b_wren, .b_rden, .b_byte_en, .b_ce_in, .b_ce_out);
  // mixed_old low is a don't-care read, so only old-data reads are compared
  brp_block_ram i_dut (.ref_clk, .arst_n, .mode, .a_width, .b_width, .parity,
    .a_new_data, .b_new_data(a_new_data), .mixed_old, .shift_len, .init_en,
    .init_row, .init_data, .a_addr, .a_wdata, .a_wren, .a_rden, .a_byte_en, .a_ce_in,
    .a_ce_out, .a_rdata, .b_addr, .b_wdata, .b_wren, .b_rden, .b_byte_en, .b_ce_in,
    .b_ce_out, .b_rdata, .fifo_full, .fifo_empty, .fifo_count);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [35:0] r36();
    return 36'({rnd(), rnd()});
  endfunction
  // packed data bit to array bit: 8 data bits in each 9-bit lane
  function automatic int phys(int p);
    return (p / 32) * 36 + (p % 32) / 8 * 9 + p % 8;
  endfunction
  // parity shapes: data bit k sits k bits above its first lane
  function automatic int physp(int ad, int wi, int k);
    return ((ad << wi) / 32) * 36 + ((ad << wi) % 32) / 8 * 9 + k;
  endfunction
  task automatic mwr(int off, int ad, int w, logic [35:0] d, logic [3:0] be);
    for (int k = 0; k < w; k++) if (be[k / 8]) mdl[phys(off + ad * w + k)] = d[k];
  endtask
  function automatic logic [35:0] mrd(int off, int ad, int w);
    logic [35:0] r;
    r = 36'h0;
    for (int k = 0; k < w; k++) r[k] = mdl[phys(off + ad * w + k)];
    return r;
  endfunction
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(logic [35:0] got, logic [35:0] exp, string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_fifo(int n);
    chk({20'h0, fifo_full, fifo_empty, fifo_count},
      {20'h0, n == (8192 >> int'(a_width)), n == 0, 14'(n)}, "fifo status");
  endtask
  task automatic rd(int p, int ad, logic [35:0] exp, string m);
    i_usr.put(p, ad, 36'h0, 0, 1, 4'h0);
    repeat (3) i_usr.go();
    chk(p ? b_rdata : a_rdata, exp, m);
  endtask
  task automatic wr2(int ob, int aa, int ba, int w, logic [35:0] d, logic [35:0] e,
                     logic [3:0] be);
    i_usr.put(0, aa, d, 1, 0, be);
    i_usr.put(1, ba, e, 1, 0, be);
    i_usr.go();
    mwr(0, aa, w, d, be);
    mwr(ob, ba, w, e, be);
  endtask
  task automatic rd2(int ob, int aa, int ba, int w);
    i_usr.put(0, aa, 36'h0, 0, 1, 4'h0);
    i_usr.put(1, ba, 36'h0, 0, 1, 4'h0);
    repeat (3) i_usr.go();
    chk(a_rdata, mrd(0, aa, w), "port a read");
    chk(b_rdata, mrd(ob, ba, w), "port b read");
  endtask
  initial begin
    #1000000;
    fails++;
    give_verdict();
  end
  initial begin
    logic [35:0] d, e;
    int w, ad;
    repeat (3) @(posedge ref_clk);
    #2;
    chk(a_rdata, 36'h0, "a rdata in reset");
    chk(b_rdata, 36'h0, "b rdata in reset");
    chk_fifo(0);
    arst_n = 1'b1;
    init_en = 1'b1;
    for (int r = 0; r < 256; r++) begin
      init_row = 8'(r);
      init_data = r36();
      for (int k = 0; k < 36; k++) mdl[r * 36 + k] = init_data[k];
      i_usr.go();
    end
    init_en = 1'b0;
    // rom drops the write and still shows the image
    ad = rnd() % 256;
    i_usr.put(0, ad, r36(), 1, 0, 4'hf);
    repeat (2) i_usr.go();
    rd(0, ad, mrd(0, ad, 32), "rom read");
    mode = BRP_TRUE;
    for (int wi = 0; wi < 6; wi++) begin
      a_width = brp_width_t'(wi);
      b_width = brp_width_t'(wi);
      w = 1 << wi;
      repeat (3) begin
        ad = rnd() % (8192 / w);
        wr2(0, ad, ad ^ 1, w, r36(), r36(), 4'(rnd()));
        rd2(0, ad ^ 1, ad, w);
      end
    end
    parity = 1'b1;
    for (int wi = 3; wi < 6; wi++) begin
      a_width = brp_width_t'(wi);
      b_width = brp_width_t'(wi);
      ad = rnd() % (8192 >> wi);
      d = r36();
      i_usr.put(0, ad, d, 1, 0, 4'hf);
      i_usr.go();
      for (int k = 0; k < (9 << (wi - 3)); k++) mdl[physp(ad, wi, k)] = d[k];
      rd(1, ad, d & ((36'h1 << (9 << (wi - 3))) - 36'h1), "parity lanes");
    end
    parity = 1'b0;
    a_width = BRP_X32;
    b_width = BRP_X32;
    for (int n = 0; n < 2; n++) begin
      a_new_data = n[0];
      ad = rnd() % 256;
      d = r36();
      e = mrd(0, ad, 32);
      i_usr.put(0, ad, d, 1, 1, 4'hf);
      i_usr.put(1, ad, d, 0, 1, 4'h0);
      repeat (3) i_usr.go();
      mwr(0, ad, 32, d, 4'hf);
      chk(a_rdata, n ? mrd(0, ad, 32) : e, "same port rdw");
      chk(b_rdata, e, "mixed port rdw");
    end
    ad = rnd() % 256;
    e = mrd(0, ad, 32);
    i_usr.ce(0, 0, 1);
    i_usr.put(0, ad, r36(), 1, 0, 4'hf);
    repeat (2) i_usr.go();
    i_usr.ce(0, 1, 1);
    rd(0, ad, e, "write with input enable low");
    rd(1, ad, e, "read before hold");
    i_usr.ce(1, 1, 0);
    rd(1, ad ^ 1, e, "output enable low holds");
    i_usr.ce(1, 1, 1);
    mode = BRP_SIMPLE;
    b_width = BRP_X8;
    ad = rnd() % 256;
    d = r36();
    i_usr.put(0, ad, d, 1, 0, 4'hf);
    i_usr.go();
    mwr(0, ad, 32, d, 4'hf);
    for (int j = 0; j < 4; j++) rd(1, ad * 4 + j, mrd(0, ad * 4 + j, 8), "mixed width");
    mode = BRP_PACKED;
    b_width = BRP_X32;
    ad = rnd() % 128;
    wr2(4096, ad, ad, 32, r36(), r36(), 4'hf);
    rd2(4096, ad, ad, 32);
    // a delay line of shift_len words shows each word shift_len shifts later
    mode = BRP_SHIFT;
    shift_len = 13'(rnd() % 5 + 1);
    for (int i = 0; i < 8; i++) begin
      d = r36();
      e = mrd(0, i % int'(shift_len), 32);
      mwr(0, i % int'(shift_len), 32, d, 4'hf);
      i_usr.put(0, 0, d, 1, 0, 4'hf);
      repeat (3) i_usr.go();
      chk(a_rdata, e, "shift output");
    end
    mode = BRP_SINGLE;
    ad = rnd() % 256;
    i_usr.put(1, ad, r36(), 1, 0, 4'hf);
    i_usr.go();
    rd(0, ad, mrd(0, ad, 32), "single port ignores b");
    mode = BRP_FIFO;
    for (int j = 0; j < 3; j++) begin
      d = r36();
      fq.push_back({4'h0, d[31:0]});
      i_usr.put(0, 0, d, 1, 0, 4'hf);
      i_usr.go();
    end
    repeat (2) i_usr.go();
    chk_fifo(3);
    // fill to capacity; the last push must be refused
    for (int j = 0; j < 254; j++) begin
      d = r36();
      if (j < 253) fq.push_back({4'h0, d[31:0]});
      i_usr.put(0, 0, d, 1, 0, 4'hf);
      i_usr.go();
    end
    repeat (2) i_usr.go();
    chk_fifo(256);
    while (fq.size() > 0) rd(1, 0, fq.pop_front(), "fifo pop");
    chk_fifo(0);
    give_verdict();
  end
endmodule // tb_brp_block_ram
`default_nettype wire
